// ==== core/can_fifo_pkg.sv ====
// Constants, field positions and carrier types for the CAN transmit FIFO block.
// Assumes a plain synchronous register port and a CAN protocol engine outside.
package can_fifo_pkg;

   localparam int         ADDR_W        = 4;
   localparam int         DATA_W        = 32;

   localparam logic [3:0] OFS_INT       = 4'h0;
   localparam logic [3:0] OFS_FIFO      = 4'h4;
   localparam logic [3:0] OFS_MODCTL    = 4'h8;

   // FIFO control fields
   localparam int         FC_PRIO_LSB   = 0;
   localparam int         FC_RTR_EN     = 2;
   localparam int         FC_SEND_REQ   = 3;
   localparam int         FC_TX_ERR     = 4;
   localparam int         FC_LOST_ARB   = 5;
   localparam int         FC_ABORTED    = 6;
   localparam int         FC_IS_TX      = 7;
   localparam int         FC_FIFO_RST   = 10;

   // Module control fields
   localparam int         MC_ON         = 15;
   localparam int         MC_MODE_LSB   = 21;

   // Interrupt register halves
   localparam int         IRQ_EN_LSB    = 16;
   localparam int         IRQ_UP_LSB    = 11;
   localparam int         IRQ_LO_MSB    = 3;

   localparam logic [2:0] MODE_CONFIG   = 3'h4;
   localparam logic [2:0] RST_OP_MODE   = 3'h4;
   localparam logic       RST_MODULE_ON = 1'h0;
   localparam logic [1:0] RST_TX_PRIO   = 2'h0;
   localparam logic [1:0] PRIO_HIGHEST  = 2'h3;
   localparam logic [1:0] PRIO_LOWEST   = 2'h0;

   typedef struct packed {
      logic invalid_msg;
      logic bus_wake;
      logic bus_error;
      logic system_error;
      logic rx_overflow;
      logic mode_change;
      logic timestamp;
      logic rx_buffer;
      logic tx_buffer;
   } irq_vec_t;

   localparam irq_vec_t   RST_IRQ       = 9'h000;

   typedef struct packed {
      logic invalid_msg;
      logic bus_wake;
      logic bus_error;
      logic system_error;
      logic rx_overflow;
      logic timestamp;
      logic rx_buffer;
   } ext_event_t;

   typedef struct packed {
      logic msg_done;
      logic fifo_drained;
      logic lost_arb;
      logic bus_err;
      logic msg_aborted;
      logic remote_rx;
   } tx_status_t;

   function automatic logic [15:0] irq_pack(input irq_vec_t v);
      return {v[8:4], 7'h00, v[3:0]};
   endfunction

   function automatic irq_vec_t irq_unpack(input logic [15:0] h);
      return {h[15:IRQ_UP_LSB], h[IRQ_LO_MSB:0]};
   endfunction

endpackage

// ==== core/can_fifo_tx_and_interrupts.sv ====
// Transmit request control of one CAN message FIFO plus the interrupt register.
// Assumes a protocol engine reporting one-cycle status pulses on tx_status.
//
// Functional notes
// R01: On a transmit FIFO, writing one to send_request starts sending the queued messages.
// R02: send_request clears itself only once every queued message has been sent successfully; the code also clears it on msg_aborted or FIFO reset.
// R03: Writing zero to send_request while it is one requests an abort of the pending message.
// R04: On a receive FIFO, writes to send_request have no effect.
// R05: With auto_remote_reply_en one, a received remote request sets send_request, else it is untouched.
// R06: tx_priority orders FIFOs, 11 highest down to 00 lowest.
// R07: msg_aborted_flag is one after an abort, zero after success, and updates on completion, abort or FIFO reset.
// R08: lost_arbitration_flag is set when a message loses arbitration while being sent.
// R09: tx_bus_error_flag is set when a bus error hits a message being sent.
// R10: The lost-arbitration and bus-error flags clear on any FIFO control read and on FIFO reset.
// R11: fifo_is_transmit accepts writes only while operating_mode_sel is configuration mode (100).
// R12: Interrupt enables sit in bits 31..27 and 19..16, one enabling a request.
// R13: Matching event flags sit in bits 15..11 and 3..0 and read one once the event occurred.
// R14: Bus activity raises a separately enabled and flagged wake-up source.
// R15: system_error_flag ignores software clears and clears only when the module is switched off and on.
// R16: Interrupt bits 26..20 and 10..4 read zero; all enables and flags reset to zero.
// R17: The interrupt output is high while any flag and its matching enable are both one; the code registers irq, so it follows one cycle later.
//
// Implementation choices: the address-and-strobe port and the address map.
module can_fifo_tx_and_interrupts
   import can_fifo_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rd_data,
   input  wire ext_event_t        ext_event,
   input  wire tx_status_t        tx_status,
   output logic                   irq,
   output logic                   tx_request,
   output logic                   tx_abort,
   output logic      [1:0]        tx_priority,
   output logic                   fifo_is_transmit,
   output logic                   module_on,
   output logic      [2:0]        operating_mode_sel
);

   logic            wr_int;
   logic            wr_fifo;
   logic            wr_mod;
   logic            rd_fifo;
   logic            cfg_mode;
   logic            fifo_reset;
   logic            sw_set;
   logic            sw_abort;
   logic            rtr_set;
   logic            drained;
   logic            auto_remote_reply_en;
   logic            msg_aborted_flag;
   logic            lost_arbitration_flag;
   logic            tx_bus_error_flag;
   logic            module_on_d;
   logic            on_rise;
   logic      [2:0] mode_d;
   logic      [1:0] tx_err_set;
   logic      [1:0] tx_err_q;
   irq_vec_t        irq_en;
   irq_vec_t        irq_flag;
   irq_vec_t        irq_set;
   irq_vec_t        irq_clr;
   irq_vec_t        w1c;
   logic [DATA_W-1:0] next_rd_data;

   // Register port decode
   assign wr_int   = wr_en && (addr == OFS_INT);
   assign wr_fifo  = wr_en && (addr == OFS_FIFO);
   assign wr_mod   = wr_en && (addr == OFS_MODCTL);
   assign rd_fifo  = rd_en && (addr == OFS_FIFO);
   assign cfg_mode = (operating_mode_sel == MODE_CONFIG);

   // FIFO reset is a self-clearing command bit
   assign fifo_reset = wr_fifo && wr_data[FC_FIFO_RST];

   // Software set, abort and remote-reply set of the request
   assign sw_set   = wr_fifo && fifo_is_transmit && wr_data[FC_SEND_REQ];             // R01 R04
   assign sw_abort = wr_fifo && fifo_is_transmit && !wr_data[FC_SEND_REQ] && tx_request; // R03 R04
   assign rtr_set  = tx_status.remote_rx && auto_remote_reply_en;                    // R05
   assign drained  = tx_status.msg_done && tx_status.fifo_drained;                   // R02

   // Module control: on bit and operating mode
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         module_on          <= RST_MODULE_ON;
         operating_mode_sel <= RST_OP_MODE;
      end else if (wr_mod) begin
         module_on          <= wr_data[MC_ON];
         operating_mode_sel <= wr_data[MC_MODE_LSB +: 3];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         module_on_d <= RST_MODULE_ON;
         mode_d      <= RST_OP_MODE;
      end else begin
         module_on_d <= module_on;
         mode_d      <= operating_mode_sel;
      end
   end

   assign on_rise = module_on && !module_on_d;

   // Direction is frozen outside configuration mode
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_is_transmit <= 1'h0;
      end else if (wr_fifo && cfg_mode) begin
         fifo_is_transmit <= wr_data[FC_IS_TX]; // R11
      end
   end

   // Priority is handed to the arbiter among FIFOs as written
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_priority          <= RST_TX_PRIO;
         auto_remote_reply_en <= 1'h0;
      end else if (wr_fifo) begin
         tx_priority          <= wr_data[FC_PRIO_LSB +: 2]; // R06
         auto_remote_reply_en <= wr_data[FC_RTR_EN];
      end
   end

   // Request bit; a software set in the same cycle as completion wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_request <= 1'h0;
      end else if (fifo_reset) begin
         tx_request <= 1'h0;
      end else if (sw_set || rtr_set) begin
         tx_request <= 1'h1; // R01 R05
      end else if (drained || tx_status.msg_aborted) begin
         tx_request <= 1'h0; // R02
      end
   end

   // Abort stays asserted until the engine reports the outcome
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_abort <= 1'h0;
      end else if (fifo_reset || drained || tx_status.msg_aborted) begin
         tx_abort <= 1'h0;
      end else if (sw_abort) begin
         tx_abort <= 1'h1; // R03
      end
   end

   // Outcome of the last message
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         msg_aborted_flag <= 1'h0;
      end else if (fifo_reset) begin
         msg_aborted_flag <= 1'h0; // R07
      end else if (tx_status.msg_aborted) begin
         msg_aborted_flag <= 1'h1; // R07
      end else if (tx_status.msg_done) begin
         msg_aborted_flag <= 1'h0; // R07
      end
   end

   // Errors only count while this FIFO is actually sending
   assign tx_err_set = {tx_status.lost_arb && tx_request,  // R08
                        tx_status.bus_err && tx_request};  // R09

   sticky_flags #(
      .W     (2)
   ) u_tx_err (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .set   (tx_err_set),
      .clr   ({2{rd_fifo || fifo_reset}}), // R10
      .q     (tx_err_q)
   );

   assign lost_arbitration_flag = tx_err_q[1];
   assign tx_bus_error_flag     = tx_err_q[0];

   // Interrupt enables
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en <= RST_IRQ; // R16
      end else if (wr_int) begin
         irq_en <= irq_unpack(wr_data[DATA_W-1:IRQ_EN_LSB]); // R12
      end
   end

   // Interrupt event sources
   always_comb begin
      irq_set              = RST_IRQ;
      irq_set.invalid_msg  = ext_event.invalid_msg;
      irq_set.bus_wake     = ext_event.bus_wake; // R14
      irq_set.bus_error    = ext_event.bus_error;
      irq_set.system_error = ext_event.system_error;
      irq_set.rx_overflow  = ext_event.rx_overflow;
      irq_set.mode_change  = (operating_mode_sel != mode_d);
      irq_set.timestamp    = ext_event.timestamp;
      irq_set.rx_buffer    = ext_event.rx_buffer;
      irq_set.tx_buffer    = drained;
   end

   // Write one to clear; system error only by an off-on cycle
   always_comb begin
      w1c                  = wr_int ? irq_unpack(wr_data[15:0]) : RST_IRQ;
      irq_clr              = w1c;
      irq_clr.system_error = on_rise; // R15
   end

   sticky_flags #(
      .W     (9)
   ) u_irq_flag (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .set   (irq_set),   // R13
      .clr   (irq_clr),
      .q     (irq_flag)
   );

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'h0;
      end else begin
         irq <= |(irq_flag & irq_en); // R17
      end
   end

   // Read mux; data stands one cycle only
   always_comb begin
      next_rd_data = '0;
      if (rd_en) begin
         case (addr)
            OFS_INT: begin
               next_rd_data = {irq_pack(irq_en), irq_pack(irq_flag)}; // R12 R13 R16
            end
            OFS_FIFO: begin
               next_rd_data[FC_PRIO_LSB +: 2] = tx_priority;
               next_rd_data[FC_RTR_EN]        = auto_remote_reply_en;
               next_rd_data[FC_SEND_REQ]      = tx_request;
               next_rd_data[FC_TX_ERR]        = tx_bus_error_flag;
               next_rd_data[FC_LOST_ARB]      = lost_arbitration_flag;
               next_rd_data[FC_ABORTED]       = msg_aborted_flag;
               next_rd_data[FC_IS_TX]         = fifo_is_transmit;
            end
            OFS_MODCTL: begin
               next_rd_data[MC_ON]            = module_on;
               next_rd_data[MC_MODE_LSB +: 3] = operating_mode_sel;
            end
            default: begin
               next_rd_data = '0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= next_rd_data;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking

   default disable iff (!rst_n);

   a_request_start: assert property ( // R01
      sw_set && !fifo_reset |=> tx_request)
      else $error("send request did not start");

   a_drain_clear: assert property ( // R02
      drained && !sw_set && !rtr_set && tx_request
      |=> !tx_request)
      else $error("send request not cleared after drain");

   // Request stands until the engine reports the abort outcome
   a_abort_req: assert property ( // R03
      sw_abort && !fifo_reset && !drained && !tx_status.msg_aborted
      |=> tx_abort && tx_request)
      else $error("abort not requested");

   a_rx_ignore: assert property ( // R04
      wr_fifo && !fifo_is_transmit && !tx_request && !rtr_set
      |=> !tx_request && !tx_abort)
      else $error("receive FIFO reacted to request write");

   a_remote_reply: assert property ( // R05
      tx_status.remote_rx && !fifo_reset
      |=> tx_request == ($past(auto_remote_reply_en) || $past(sw_set)
          || ($past(tx_request) && !$past(drained) && !$past(tx_status.msg_aborted))))
      else $error("remote reply request wrong");

   a_prio_follow: assert property ( // R06
      wr_fifo |=> tx_priority == $past(wr_data[1:0]))
      else $error("priority not taken");

   a_abort_outcome: assert property ( // R07
      tx_status.msg_aborted && !fifo_reset |=> msg_aborted_flag)
      else $error("aborted flag not set");

   a_done_outcome: assert property ( // R07
      tx_status.msg_done && !tx_status.msg_aborted && !fifo_reset |=> !msg_aborted_flag)
      else $error("aborted flag not cleared on success");

   a_lost_arb: assert property ( // R08
      tx_status.lost_arb && tx_request |=> lost_arbitration_flag [*1])
      else $error("lost arbitration not flagged");

   a_bus_err: assert property ( // R09
      tx_status.bus_err && tx_request |=> tx_bus_error_flag)
      else $error("bus error not flagged");

   a_read_clear: assert property ( // R10
      rd_fifo && !tx_err_set[1] |=> !lost_arbitration_flag)
      else $error("read did not clear lost arbitration");

   a_cfg_lock: assert property ( // R11
      wr_fifo && !cfg_mode |=> $stable(fifo_is_transmit))
      else $error("direction changed outside configuration");

   a_sys_err_hold: assert property ( // R15
      irq_flag.system_error && !on_rise |=> irq_flag.system_error)
      else $error("system error flag cleared by software");

   a_unimpl_zero: assert property ( // R16
      rd_en && addr == OFS_INT |=> rd_data[26:20] == 7'h00 && rd_data[10:4] == 7'h00)
      else $error("unimplemented interrupt bits not zero");

   a_irq_level: assert property ( // R17
      ##1 irq == $past(|(irq_flag & irq_en)))
      else $error("interrupt output mismatch");

   a_wake_flag: assert property ( // R14
      ext_event.bus_wake |=> irq_flag.bus_wake)
      else $error("wake flag not set");

   c_abort_seen:  cover property (sw_abort ##[1:20] tx_status.msg_aborted);
   c_drain_seen:  cover property (sw_set ##[1:50] drained);
   c_remote_seen: cover property (rtr_set ##1 tx_request);
   c_irq_seen:    cover property ($rose(irq));
   c_mode_seen:   cover property (irq_set.mode_change ##1 irq_flag.mode_change);

endmodule // can_fifo_tx_and_interrupts

// ==== core/sticky_flags.sv ====
// Bank of sticky flags; hardware set wins over any clear in the same cycle.
// Assumes set and clear are synchronous to clk.
module sticky_flags
   import can_fifo_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] q
);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= (q & ~clr) | set;
      end
   end

   a_set_wins: assert property (@(posedge clk) disable iff (!rst_n) // R13
      |set |=> ((q & $past(set)) == $past(set)))
      else $error("sticky flag set was lost");

endmodule // sticky_flags

// ==== verif/can_engine_model.sv ====
// Behavioural protocol engine facing the FIFO's transmit side.
// Assumes the bench names a job and a latency with a one-cycle go pulse.
module can_engine_model
   import can_fifo_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       tx_request,
   input  wire logic       tx_abort,
   input  wire logic [2:0] job,
   input  wire logic       go,
   input  wire logic [3:0] lat,
   output tx_status_t      tx_status
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   logic [3:0] acnt;
   logic [2:0] pend;
   logic       busy;
   logic       abusy;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_status <= '0;
         cnt <= 4'h0;
         acnt <= 4'h0;
         pend <= 3'h0;
         busy <= 1'b0;
         abusy <= 1'b0;
      end else begin
         tx_status <= '0;
         if (go) begin
            busy <= 1'b1;
            pend <= job;
            cnt <= lat;
         end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (busy) begin
            busy <= 1'b0;
            // Only a message on the wire can finish, lose or fail
            tx_status.msg_done <= tx_request && pend < 3'h2;
            tx_status.fifo_drained <= tx_request && pend == 3'h1;
            tx_status.lost_arb <= tx_request && pend == 3'h2;
            tx_status.bus_err <= tx_request && pend == 3'h3;
            tx_status.remote_rx <= pend == 3'h4;
         end
         if (tx_abort && !abusy) begin
            abusy <= 1'b1;
            acnt <= lat;
         end else if (abusy && acnt != 4'h0) begin
            acnt <= acnt - 4'h1;
         end else if (abusy) begin
            abusy <= 1'b0;
            // Stale restart after the abort ended must stay silent
            tx_status.msg_aborted <= tx_abort;
         end
      end
   end
endmodule // can_engine_model

// ==== verif/tb.sv ====
// Self-checking bench for the CAN FIFO transmit and interrupt block.
// Assumes can_engine_model stands on the engine side of the block.
module tb
   import can_fifo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              ref_clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wr_data = 32'h0;
   logic              wr_en = 1'b0;
   logic              rd_en = 1'b0;
   logic [DATA_W-1:0] rd_data;
   ext_event_t        ext_event = '0;
   tx_status_t        tx_status;
   logic              irq, tx_request, tx_abort, fifo_is_transmit, module_on;
   logic [1:0]        tx_priority;
   logic [2:0]        operating_mode_sel;
   logic [2:0]        job = 3'h0;
   logic              go = 1'b0;
   logic [3:0]        lat = 4'h5;
   int                fails = 0;
   int                n_tests = 0;
   logic [31:0]       seed = 32'h0001_0399;
   logic [31:0]       d, r;
   logic [15:0]       fl;

   always #20 ref_clk = ~ref_clk;

   can_fifo_tx_and_interrupts uut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_event(ext_event), .tx_status(tx_status),
      .irq(irq), .tx_request(tx_request), .tx_abort(tx_abort), .tx_priority(tx_priority),
      .fifo_is_transmit(fifo_is_transmit), .module_on(module_on), .operating_mode_sel(operating_mode_sel));
   can_engine_model engine (.ref_clk(ref_clk), .rst_n(rst_n), .tx_request(tx_request),
      .tx_abort(tx_abort), .job(job), .go(go), .lat(lat), .tx_status(tx_status));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic b(input logic seen, input logic exp);
      chk({31'h0, seen}, {31'h0, exp});
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] fmap(input logic [6:0] e);
      return {e[6:2], 7'h00, 1'b0, e[1:0], 1'b0};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic pulse(input logic [6:0] e);
      @(posedge ref_clk);
      ext_event <= e;
      @(posedge ref_clk);
      ext_event <= '0;
   endtask
   // Engine answers lat+1 cycles after go; wait on its pulse, never a fixed delay
   task automatic eng(input logic [2:0] j);
      @(posedge ref_clk);
      job <= j;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      for (int i = 0; i < 40 && tx_status === '0; i++) @(posedge ref_clk) #1;
      if (tx_status === '0) begin
         fails++;
         end_of_test();
      end
      @(posedge ref_clk) #1;
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(4'h0);
      chk(d, 32'h0);
      rd(4'h4);
      chk(d, 32'h0);
      rd(4'h8);
      chk(d, 32'h0080_0000);
      rd(4'hC);
      chk(d, 32'h0);
      b(irq, 1'b0);
      $display("test reset done");

      wr(4'h8, 32'h0080_8000);
      wr(4'h0, 32'hFFFF_FFFF);
      rd(4'h0);
      chk(d, 32'hF80F_0000);
      fl = 16'h0;
      for (int k = 0; k < 12; k++) begin
         r = xs();
         pulse((k == 0) ? 7'h7F : r[6:0]);
         fl |= fmap((k == 0) ? 7'h7F : r[6:0]);
         rd(4'h0);
         chk(d, {16'hF80F, fl});
         b(irq, |fl);
         wr(4'h0, {16'hF80F, r[31:16]});
         fl &= ~r[31:16] | 16'h1000;
      end
      wr(4'h0, 32'h0000_FFFF);
      rd(4'h0);
      chk(d, 32'h0000_1000);
      b(irq, 1'b0);
      wr(4'h0, 32'h1000_0000);
      rd(4'h0);
      b(irq, 1'b1);
      wr(4'h8, 32'h0080_0000);
      wr(4'h8, 32'h0080_8000);
      rd(4'h0);
      chk(d, 32'h1000_0000);
      b(irq, 1'b0);
      $display("test interrupts done");

      // Direction must stand before a request is honoured
      wr(4'h4, 32'h80);
      wr(4'h4, 32'h88);
      b(tx_request, 1'b1);
      wr(4'h4, 32'h80);
      b(tx_abort, 1'b1);
      for (int i = 0; i < 40 && tx_abort === 1'b1; i++) @(posedge ref_clk) #1;
      b(tx_abort, 1'b0);
      if (tx_abort !== 1'b0) end_of_test();
      b(tx_request, 1'b0);
      rd(4'h4);
      chk(d, 32'hC0);
      wr(4'h4, 32'h88);
      eng(3'h0);
      b(tx_request, 1'b1);
      eng(3'h2);
      eng(3'h3);
      rd(4'h4);
      chk(d, 32'hB8);
      rd(4'h4);
      chk(d, 32'h88);
      eng(3'h1);
      b(tx_request, 1'b0);
      rd(4'h4);
      chk(d, 32'h80);
      rd(4'h0);
      b(d[0], 1'b1);
      wr(4'h4, 32'h88);
      eng(3'h2);
      wr(4'h4, 32'h488);
      rd(4'h4);
      chk(d & 32'h38, 32'h0);
      $display("test transmit done");

      wr(4'h4, 32'h80);
      eng(3'h4);
      b(tx_request, 1'b0);
      wr(4'h4, 32'h84);
      eng(3'h4);
      b(tx_request, 1'b1);
      wr(4'h4, 32'h484);
      $display("test remote done");

      for (int p = 0; p < 8; p++) begin
         r = (p < 4) ? p : xs();
         wr(4'h4, {30'h20, r[1:0]});
         chk({30'h0, tx_priority}, {30'h0, r[1:0]});
      end
      $display("test priority done");

      wr(4'h0, 32'h0000_FFFF);
      wr(4'h8, 32'h0000_8000);
      b(module_on, 1'b1);
      chk({29'h0, operating_mode_sel}, 32'h0);
      wr(4'h4, 32'h0);
      b(fifo_is_transmit, 1'b1);
      rd(4'h0);
      b(d[3], 1'b1);
      wr(4'h8, 32'h0080_8000);
      wr(4'h4, 32'h0);
      b(fifo_is_transmit, 1'b0);
      wr(4'h4, 32'h08);
      b(tx_request, 1'b0);
      rd(4'h4);
      b(d[3], 1'b0);
      $display("test modes done");
      end_of_test();
   end
endmodule // tb
